/* File: inc/adc_ctrl_pkg.sv */
// constants, types and helpers shared by the converter control block
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RESULT_LOW = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFS_SETUP = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_PIN_CONFIG = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SETUP_TEST_BIT = 7;
  localparam int SETUP_POWER_OFF_BIT = 6;
  localparam int SETUP_REF_CHANNEL_BIT = 5;
  localparam int SETUP_BANDGAP_EN_BIT = 4;
  localparam int SETUP_REF_SOURCE_BIT = 3;
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_PENDING_BIT = 6;
  localparam int IRQ_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RESET = 8'hc0;
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
  localparam logic [2:0] CHANNEL_RESET = 3'h0;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [2:0] CLK_SEL_DIV2 = 3'h0;

  // conversion sequencer, gray coded along idle -> armed -> converting
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_CONVERTING = 2'h3
  } conv_state_type;

  // divide ratio of a clock select code; zero marks an undefined code
  function automatic logic [5:0] div_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: div_ratio = 6'h02;
      3'h1: div_ratio = 6'h08;
      3'h2: div_ratio = 6'h20;
      3'h4: div_ratio = 6'h01;
      3'h5: div_ratio = 6'h04;
      3'h6: div_ratio = 6'h10;
      default: div_ratio = 6'h00;
    endcase
  endfunction

endpackage

/* File: src/adc_clock_divider.sv */
// converter clock enable generator derived from the system clock
`timescale 1ns/1ps
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick_q
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  wire logic [5:0] ratio = div_ratio(sel);
  // wrap on >= so a smaller ratio picked mid-count cannot overrun
  wire logic hit = run && (ratio != 6'h00) && ({1'b0, cnt_q} >= ratio - 6'h01); // [R10]

  // undefined codes and power-off clear the counter and keep it at zero
  always_comb begin
    cnt_d = cnt_q;
    if (!run || ratio == 6'h00) begin
      cnt_d = 5'h00;
    end else if (hit) begin
      cnt_d = 5'h00;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= hit;
    end
  end

  sequence steady_div2;
    run && sel == CLK_SEL_DIV2;
  endsequence

  a_div2_period: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
    (tick_q and steady_div2) ##1 steady_div2 ##1 steady_div2 |-> tick_q && !$past(tick_q))
    else $error("divide by two tick period wrong");

endmodule

/* File: src/adc_result_store.sv */
// holding registers for the two result bytes
`timescale 1ns/1ps
module adc_result_store
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [11:0] data,
  output logic [7:0] high_q,
  output logic [7:0] low_q
);

  // only a finished conversion changes the bytes; bus writes never reach here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_q <= 8'h00;
      low_q <= 8'h00;
    end else if (load) begin // [R17]
      high_q <= data[11:4]; // [R01]
      low_q <= {data[3:0], 4'h0}; // [R02]
    end
  end

  a_high_byte_map: assert property (@(posedge clk) disable iff (!arst_n) // [R01]
    load |=> high_q == $past(data[11:4]))
    else $error("high byte does not hold result bits 11 to 4");

  a_low_byte_map: assert property (@(posedge clk) disable iff (!arst_n) // [R02]
    load |=> low_q[7:4] == $past(data[3:0]) && low_q[3:0] == 4'h0)
    else $error("low byte packing wrong");

  a_result_hold: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
    !load |=> $stable(high_q) && $stable(low_q))
    else $error("result changed without a conversion");

endmodule

/* File: src/adc_control_and_result_regs.sv */
// converter control registers, routing, sequencing and result bytes on wishbone
//
// Contract
// R01: result high byte carries conversion bits 11 down to 4.
// R02: result low byte bits 7..4 carry bits 3..0; low nibble reads zero.
// R03: with reference channel off, one of eight inputs is routed by channel bits.
// R04: reference channel bit 5 routes band-gap voltage instead of any pin.
// R05: power bit 6 at zero turns converter on; resets to one, off.
// R06: band-gap enable bit 4 enables reference; cleared, output tied to ground.
// R07: band-gap powers down when not routed and low-voltage monitor is off.
// R08: reference source bit 3 picks analog supply at zero, reference pin at one.
// R09: external reference disables reference pin I/O; internal leaves it usable.
// R10: clock select divides system clock by 2,8,32,1,4,16; 011/111 undefined.
// R11: setup bit 7 is a test bit that resets to one and reads one.
// R12: each pin config bit set makes its port pin an analog input.
// R13: software waits band-gap settle time before converting after enabling it.
// R14: start 0-1-0 starts; start held high resets converter, pending flag one.
// R15: conversion end clears pending flag and raises interrupt request together.
// R16: result bytes update before pending clears and hold until next completion.
// R17: result bytes ignore software writes; only conversions change them.
`timescale 1ns/1ps
module adc_control_and_result_regs
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic low_voltage_monitor_enable,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic conv_start,
  output logic conv_reset,
  output logic conv_clk_en,
  output logic converter_power_on,
  output logic [7:0] analog_channel_sel,
  output logic bandgap_to_converter,
  output logic bandgap_power_on,
  output logic bandgap_grounded,
  output logic ref_from_pin,
  output logic ref_pin_io_disable,
  output logic [7:0] pin_analog_mask
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic [6:0] setup_q;
  logic [2:0] channel_q;
  logic [7:0] pin_cfg_q;
  logic [7:0] irq_en_q;
  logic irq_done_q;
  logic start_q;
  logic pending_q;
  logic finish_q;
  conv_state_type state_q;
  conv_state_type state_d;
  logic [7:0] res_high;
  logic [7:0] res_low;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait state: ack follows the request by one edge, writes land on the next edge, where ack is sampled high
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic wr_lane = req && wb_we_i && ack_q && wb_sel_i[0];
  wire logic wr_setup = wr_lane && wb_adr_i == OFS_SETUP;
  wire logic wr_ctrl = wr_lane && wb_adr_i == OFS_CONTROL;
  wire logic wr_pins = wr_lane && wb_adr_i == OFS_PIN_CONFIG;
  wire logic wr_clear = wr_lane && wb_adr_i == OFS_IRQ_CLEAR;
  wire logic wr_irq_en = wr_lane && wb_adr_i == OFS_IRQ_ENABLE;
  wire logic [7:0] wr_byte = wb_dat_i[7:0];

  // start edges as written by software
  wire logic start_rise = wr_ctrl && wr_byte[CTRL_START_BIT] && !start_q; // [R14]
  wire logic start_fall = wr_ctrl && !wr_byte[CTRL_START_BIT] && start_q; // [R14]
  wire logic conv_accept = conv_done && state_q == ST_CONVERTING;

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  // the test bit has no storage: it is wired to one
  wire logic [7:0] setup_view = {1'b1, setup_q}; // [R11]
  wire logic [7:0] ctrl_view = {start_q, pending_q, 3'h0, channel_q};
  wire logic [7:0] status_view = {7'h00, irq_done_q};
  // result bytes are read-only: their offsets decode for reads only
  wire logic [7:0] rd_byte =
    (wb_adr_i == OFS_RESULT_LOW) ? res_low :
    (wb_adr_i == OFS_RESULT_HIGH) ? res_high :
    (wb_adr_i == OFS_SETUP) ? setup_view :
    (wb_adr_i == OFS_CONTROL) ? ctrl_view :
    (wb_adr_i == OFS_PIN_CONFIG) ? pin_cfg_q :
    (wb_adr_i == OFS_IRQ_STATUS) ? status_view :
    (wb_adr_i == OFS_IRQ_ENABLE) ? irq_en_q : 8'h00; // [R17]

  // ack and read data; unmapped offsets answer with zero data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_q <= SETUP_RESET[6:0]; // [R05]
      channel_q <= CHANNEL_RESET;
      pin_cfg_q <= PIN_CONFIG_RESET;
      irq_en_q <= IRQ_ENABLE_RESET;
    end else begin
      if (wr_setup) begin
        setup_q <= wr_byte[6:0];
      end
      if (wr_ctrl) begin
        channel_q <= wr_byte[2:0];
      end
      if (wr_pins) begin
        pin_cfg_q <= wr_byte;
      end
      if (wr_irq_en) begin
        irq_en_q <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // analog routing and power
  // ----------------------------------------------------------------
  wire logic ref_channel = setup_q[SETUP_REF_CHANNEL_BIT];
  wire logic bandgap_en = setup_q[SETUP_BANDGAP_EN_BIT];
  assign converter_power_on = !setup_q[SETUP_POWER_OFF_BIT]; // [R05]
  // band-gap selection blanks every pin so two sources never share the node
  assign analog_channel_sel = ref_channel ? 8'h00 : (8'h01 << channel_q); // [R03] [R04]
  assign bandgap_to_converter = ref_channel; // [R04]
  // the band-gap draws power only while somebody uses it
  assign bandgap_power_on = bandgap_en && (ref_channel || low_voltage_monitor_enable); // [R06] [R07]
  assign bandgap_grounded = !bandgap_power_on; // [R06]
  assign ref_from_pin = setup_q[SETUP_REF_SOURCE_BIT]; // [R08]
  assign ref_pin_io_disable = setup_q[SETUP_REF_SOURCE_BIT]; // [R09]
  assign pin_analog_mask = pin_cfg_q; // [R12]

  // converter clock enable, stopped while the converter is off
  adc_clock_divider u_divider (
    .clk(clk),
    .arst_n(arst_n),
    .run(converter_power_on),
    .sel(setup_q[2:0]),
    .tick_q(conv_clk_en)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // settle time after enabling the band-gap is software's to honour; no hold-off here
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_rise) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (start_fall) begin
          state_d = ST_CONVERTING; // [R14]
        end
      end
      ST_CONVERTING: begin
        if (start_rise) begin
          state_d = ST_ARMED; // [R14]
        end else if (conv_accept) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // pending clears one edge after the results load, so a poller never reads stale bytes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      pending_q <= 1'b1;
      finish_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_ctrl) begin
        start_q <= wr_byte[CTRL_START_BIT];
      end
      finish_q <= conv_accept && !start_rise; // [R16]
      if (start_rise) begin
        pending_q <= 1'b1; // [R14]
      end else if (finish_q) begin
        pending_q <= 1'b0; // [R15]
      end
    end
  end

  assign conv_start = state_q == ST_ARMED && start_fall;
  assign conv_reset = state_q == ST_ARMED; // [R14]

  adc_result_store u_results (
    .clk(clk),
    .arst_n(arst_n),
    .load(conv_accept),
    .data(conv_result),
    .high_q(res_high),
    .low_q(res_low)
  );

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  // a completion in the same cycle as a clear keeps the flag set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_done_q <= 1'b0;
    end else if (finish_q) begin
      irq_done_q <= 1'b1; // [R15]
    end else if (wr_clear && wr_byte[IRQ_DONE_BIT]) begin
      irq_done_q <= 1'b0;
    end
  end

  assign irq = irq_done_q && irq_en_q[IRQ_DONE_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence arm_write;
    start_rise;
  endsequence

  sequence finish_seen;
    conv_accept && !start_rise ##1 !start_rise;
  endsequence

  a_channel_onehot: assert property (@(posedge clk) disable iff (!arst_n) // [R03]
    !ref_channel |-> $onehot(analog_channel_sel) && analog_channel_sel[channel_q])
    else $error("channel routing not one-hot");

  a_bandgap_route: assert property (@(posedge clk) disable iff (!arst_n) // [R04]
    ref_channel |-> analog_channel_sel == 8'h00 && bandgap_to_converter)
    else $error("band-gap not routed alone");

  a_power_gates_clk: assert property (@(posedge clk) disable iff (!arst_n) // [R05]
    !converter_power_on ##1 !converter_power_on |-> !conv_clk_en)
    else $error("converter clock running while off");

  a_bandgap_off: assert property (@(posedge clk) disable iff (!arst_n) // [R07]
    (!bandgap_en || (!ref_channel && !low_voltage_monitor_enable)) |-> !bandgap_power_on && bandgap_grounded)
    else $error("band-gap powered while unused");

  a_ref_pin_share: assert property (@(posedge clk) disable iff (!arst_n) // [R09]
    ref_pin_io_disable == ref_from_pin && ref_from_pin == setup_view[SETUP_REF_SOURCE_BIT])
    else $error("reference pin sharing wrong");

  a_test_bit_one: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
    ack_q && !wb_we_i && wb_adr_i == OFS_SETUP |-> wb_dat_o[SETUP_TEST_BIT])
    else $error("test bit does not read one");

  a_start_arms: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
    arm_write |=> pending_q && conv_reset && !conv_start)
    else $error("start rise did not reset converter");

  a_finish_flags: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
    finish_seen |=> !pending_q && irq_done_q)
    else $error("completion flags not updated together");

  a_result_before_flag: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
    $fell(pending_q) |-> $past(conv_accept, 2) && $stable(res_high))
    else $error("pending cleared before results stored");

endmodule

/* File: testbench/analog_converter_model.sv */
// behavioural analog converter that answers start pulses with a result
`timescale 1ns/1ps
module analog_converter_model #(
  parameter int LATENCY = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic conv_start,
  input wire logic conv_reset,
  input wire logic [11:0] sample,
  output logic conv_done,
  output logic [11:0] conv_result
);
  int cnt_q;
  logic [11:0] last_q;
  // result is valid only with the done pulse; otherwise inverted so stale data never matches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
      conv_done <= 1'b0;
      last_q <= 12'h000;
      conv_result <= 12'hfff;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~last_q;
      // the start pulse arrives in the last armed cycle, so it outranks the reset level
      if (conv_start) begin
        cnt_q <= LATENCY;
      end else if (conv_reset) begin
        cnt_q <= 0; // start held high aborts the conversion
      end else if (cnt_q == 1) begin
        cnt_q <= 0;
        conv_done <= 1'b1;
        conv_result <= sample;
        last_q <= sample;
      end else if (cnt_q > 1) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

/* File: testbench/tb_adc_control_and_result_regs.sv */
// self-checking bench for the converter control and result registers
`timescale 1ns/1ps
module tb_adc_control_and_result_regs;
  import adc_ctrl_pkg::*;
  logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, lvm_en, conv_done;
  logic [7:0] wb_adr_i, chan, mask;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [11:0] conv_result, sample;
  logic conv_start, conv_reset, clk_en, pwr_on, bg_conv, bg_pwr, bg_gnd, ref_pin, ref_io_dis;
  int error_cnt = 0;
  int total_checks = 0;

  adc_control_and_result_regs adc_control_and_result_regs_inst (.clk(clk), .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .low_voltage_monitor_enable(lvm_en), .conv_done(conv_done), .conv_result(conv_result),
    .conv_start(conv_start), .conv_reset(conv_reset), .conv_clk_en(clk_en),
    .converter_power_on(pwr_on), .analog_channel_sel(chan), .bandgap_to_converter(bg_conv),
    .bandgap_power_on(bg_pwr), .bandgap_grounded(bg_gnd), .ref_from_pin(ref_pin),
    .ref_pin_io_disable(ref_io_dis), .pin_analog_mask(mask));
  analog_converter_model analog_converter_model_inst (.clk(clk), .arst_n(arst_n),
    .conv_start(conv_start), .conv_reset(conv_reset), .sample(sample),
    .conv_done(conv_done), .conv_result(conv_result));

  // ----------------------------------------------------------------
  // clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is about a thousand cycles; the watchdog at 20000 cycles leaves wide margin
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask
  // classic cycle: request held until ack is sampled high at a rising edge; data taken and request dropped there
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    wb_sel_i <= 4'h1;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("Error at %0t: no bus ack", $time);
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] d;
    wb(1'b1, adr, dat, d);
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] d;
    wb(1'b0, adr, 8'h00, d);
    check_byte(d, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(OFS_SETUP, 8'hc0);
    rd_chk(OFS_CONTROL, 8'h40);
    rd_chk(8'h20, 8'h00);
    check_bit(pwr_on, 1'b0);
    check_byte(chan, 8'h01);
    check_bit(bg_gnd, 1'b1);
  endtask
  task automatic t_setup;
    wr(OFS_SETUP, 8'h00);
    rd_chk(OFS_SETUP, 8'h80);
    check_bit(pwr_on, 1'b1);
    check_bit(ref_pin, 1'b0);
    check_bit(ref_io_dis, 1'b0);
    wr(OFS_SETUP, 8'h38);
    check_byte(chan, 8'h00);
    check_bit(bg_conv, 1'b1);
    check_bit(bg_pwr, 1'b1);
    check_bit(ref_pin, 1'b1);
    check_bit(ref_io_dis, 1'b1);
    wr(OFS_SETUP, 8'h10);
    check_bit(bg_pwr, 1'b0);
    check_bit(bg_gnd, 1'b1);
    @(posedge clk);
    lvm_en <= 1'b1;
    @(negedge clk);
    check_bit(bg_pwr, 1'b1);
    wr(OFS_SETUP, 8'h00);
    check_bit(bg_gnd, 1'b1);
    @(posedge clk);
    lvm_en <= 1'b0;
  endtask
  task automatic t_channels;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CONTROL, 8'(c));
      check_byte(chan, 8'h01 << c);
    end
    wr(OFS_PIN_CONFIG, 8'ha5);
    check_byte(mask, 8'ha5);
    rd_chk(OFS_PIN_CONFIG, 8'ha5);
  endtask
  // ratio table per select code; 0 marks the undefined codes
  task automatic t_divider;
    int rat[8] = '{2, 8, 32, 0, 1, 4, 16, 0};
    int cnt;
    for (int s = 0; s < 9; s++) begin
      wr(OFS_SETUP, (s == 8) ? 8'h40 : 8'(s));
      repeat (4) @(negedge clk);
      cnt = 0;
      repeat (64) begin
        @(negedge clk);
        if (clk_en === 1'b1) cnt++;
      end
      check_byte(8'(cnt), (s == 8 || rat[s] == 0) ? 8'h00 : 8'(64 / rat[s]));
    end
    wr(OFS_SETUP, 8'h00);
  endtask
  task automatic convert(input logic [11:0] v, input logic [2:0] c);
    int n;
    @(posedge clk);
    sample <= v;
    wr(OFS_CONTROL, {5'h10, c});
    check_bit(conv_reset, 1'b1);
    rd_chk(OFS_CONTROL, {5'h18, c});
    wr(OFS_CONTROL, {5'h00, c});
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check_bit(irq, 1'b1);
    rd_chk(OFS_CONTROL, {5'h00, c});
  endtask
  task automatic t_conversion;
    wr(OFS_IRQ_ENABLE, 8'h01);
    // route the band-gap and let it settle before the first conversion
    wr(OFS_SETUP, 8'h30);
    repeat (20) @(negedge clk);
    convert(12'habc, 3'h2);
    rd_chk(OFS_RESULT_HIGH, 8'hab);
    rd_chk(OFS_RESULT_LOW, 8'hc0);
    rd_chk(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_RESULT_HIGH, 8'h00);
    wr(OFS_RESULT_LOW, 8'h3f);
    rd_chk(OFS_RESULT_HIGH, 8'hab);
    rd_chk(OFS_RESULT_LOW, 8'hc0);
    wr(OFS_IRQ_ENABLE, 8'h00);
    check_bit(irq, 1'b0);
    wr(OFS_IRQ_CLEAR, 8'h01);
    rd_chk(OFS_IRQ_STATUS, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h01);
    // start left high: no conversion, results keep the old value
    @(posedge clk);
    sample <= 12'h123;
    wr(OFS_CONTROL, 8'h80);
    repeat (30) @(negedge clk);
    check_bit(irq, 1'b0);
    rd_chk(OFS_CONTROL, 8'hc0);
    rd_chk(OFS_RESULT_HIGH, 8'hab);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_IRQ_CLEAR, 8'h01);
    convert(12'h5a3, 3'h7);
    rd_chk(OFS_RESULT_HIGH, 8'h5a);
    rd_chk(OFS_RESULT_LOW, 8'h30);
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'h1;
    lvm_en = 1'b0;
    sample = 12'h000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_setup();
    t_channels();
    t_divider();
    t_conversion();
    tally_and_finish();
  end
endmodule
